// *** verilog/rtc_pkg.sv ***
// ==========================================================
// Register map, field layout and timing of the clock block
package rtc_pkg;
  // ==========================================================
  // Register offsets, read address; write address adds RTC_WR_FLAG
  localparam logic [7:0] RTC_WR_FLAG = 8'h80;
  localparam logic [7:0] RTC_CTRL_OFS = 8'h0E;
  localparam logic [7:0] RTC_STAT_OFS = 8'h0F;
  localparam logic [7:0] RTC_TRIM_OFS = 8'h10;
  localparam logic [7:0] RTC_TEMPH_OFS = 8'h11;
  localparam logic [7:0] RTC_TEMPL_OFS = 8'h12;
  localparam logic [7:0] RTC_TCTL_OFS = 8'h13;
  localparam logic [7:0] RTC_MPTR_OFS = 8'h18;
  localparam logic [7:0] RTC_MWIN_OFS = 8'h19;
  // ==========================================================
  // Field positions of clock_control
  localparam int CTL_OSC_DIS = 7;
  localparam int CTL_BAT_INT = 6;
  localparam int CTL_FORCE_TEMP_CONVERSION = 5;
  localparam int CTL_RATE_HI = 4;
  localparam int CTL_RATE_LO = 3;
  localparam int CTL_IRQ_SEL = 2;
  localparam int CTL_A2_IE = 1;
  localparam int CTL_A1_IE = 0;
  // Field positions of clock_status, then of the temperature control register
  localparam int STA_OSF = 7;
  localparam int STA_BAT_REF = 6;
  localparam int STA_CRATE_HI = 5;
  localparam int STA_CRATE_LO = 4;
  localparam int STA_REF_EN = 3;
  localparam int STA_BUSY = 2;
  localparam int STA_A2F = 1;
  localparam int STA_A1F = 0;
  localparam int TCTL_BAT_TD = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RTC_CTRL_RST = 8'h1C;
  localparam logic [7:0] RTC_STAT_RST = 8'h88;
  localparam logic [7:0] RTC_ZERO_RST = 8'h00;
  localparam logic [9:0] RTC_TEMP_RST = 10'h000;
  // ==========================================================
  // Timing
  localparam int RTC_CLK_HZ = 200_000_000;
  localparam int RTC_BUSY_DLY_MS = 2;
  localparam int RTC_BUSY_DLY_CYC = RTC_BUSY_DLY_MS * (RTC_CLK_HZ / 1000);
  localparam logic [9:0] RTC_COMP_BASE_S = 10'h040;
  // Divider taps of the 32.768 kHz reference for each wave rate
  localparam int RTC_DIV_W = 15;
  localparam int RTC_TAP_1HZ = 14;
  localparam int RTC_TAP_1K = 4;
  localparam int RTC_TAP_4K = 2;
  localparam int RTC_TAP_8K = 1;
  // ==========================================================
  // Conversion engine states
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_HOLD = 2'b01,
    CV_RUN = 2'b10
  } rtc_force_temp_conversion_state_t;
endpackage : rtc_pkg

// *** verilog/rtc_force_temp_conversion_if.sv ***
`timescale 1ns/1ps
// ==========================================================
// Link between register bank and conversion engine
interface rtc_force_temp_conversion_if;
  logic force_req;
  logic auto_req;
  logic sensor_done;
  logic [9:0] sensor_temp;
  logic force_busy;
  logic busy;
  logic auto_ack;
  logic done;
  logic sensor_start;
  logic trim_apply;
  logic [9:0] temp;
  modport engine(input force_req, auto_req, sensor_done, sensor_temp,
    output force_busy, busy, auto_ack, done, sensor_start, trim_apply, temp);
  modport regs(output force_req, auto_req, sensor_done, sensor_temp,
    input force_busy, busy, auto_ack, done, sensor_start, trim_apply, temp);
endinterface : rtc_force_temp_conversion_if

// *** verilog/rtc_force_temp_conversion_engine.sv ***
`timescale 1ns/1ps
// ==========================================================
// Temperature conversion sequencer
module rtc_force_temp_conversion_engine import rtc_pkg::*; #(
  parameter int unsigned BUSY_DELAY = RTC_BUSY_DLY_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  rtc_force_temp_conversion_if.engine cv
);
  localparam int CW = $clog2(BUSY_DELAY + 1);
  rtc_force_temp_conversion_state_t state_reg;
  logic [CW-1:0] hold_cnt_reg;
  logic force_reg;
  logic busy_reg;
  logic ack_reg;
  logic done_reg;
  logic start_reg;
  logic trim_reg;
  logic [9:0] temp_reg;
  logic take_force;
  logic take_auto;
  logic hold_end;
  logic finish;

  // Request decode
  assign take_force = (state_reg == CV_IDLE) && cv.force_req;
  assign take_auto = (state_reg == CV_IDLE) && !cv.force_req && cv.auto_req;
  assign hold_end = (state_reg == CV_HOLD) && (hold_cnt_reg == CW'(BUSY_DELAY - 1));
  assign finish = (state_reg == CV_RUN) && cv.sensor_done;

  // Sequencer; forced runs wait before raising busy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= CV_IDLE;
      hold_cnt_reg <= '0;
    end else begin
      case (state_reg)
        CV_IDLE: begin
          hold_cnt_reg <= '0;
          if (take_force) begin
            state_reg <= CV_HOLD;
          end else if (take_auto) begin
            state_reg <= CV_RUN;
          end
        end
        CV_HOLD: begin
          hold_cnt_reg <= hold_cnt_reg + 1'b1;
          if (hold_end) begin
            state_reg <= CV_RUN;
          end
        end
        CV_RUN: begin
          if (finish) begin
            state_reg <= CV_IDLE;
          end
        end
        default: state_reg <= CV_IDLE;
      endcase
    end
  end

  // Sensor start pulse and busy flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      start_reg <= take_auto || hold_end;
      if (take_auto || hold_end) begin
        busy_reg <= 1'b1;
      end else if (finish) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Forced-conversion flag, held until the result arrives
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      force_reg <= 1'b0;
    end else if (take_force) begin
      force_reg <= 1'b1;
    end else if (finish) begin
      force_reg <= 1'b0;
    end
  end

  // Result capture and trim application
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_reg <= RTC_TEMP_RST;
      trim_reg <= 1'b0;
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      done_reg <= finish;
      ack_reg <= take_auto;
      trim_reg <= finish && (force_reg || (cv.sensor_temp != temp_reg));
      if (finish) begin
        temp_reg <= cv.sensor_temp;
      end
    end
  end

  assign cv.force_busy = force_reg;
  assign cv.busy = busy_reg;
  assign cv.auto_ack = ack_reg;
  assign cv.done = done_reg;
  assign cv.sensor_start = start_reg;
  assign cv.trim_apply = trim_reg;
  assign cv.temp = temp_reg;

  // ==========================================================
  // Checks
  busy_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(force_reg) |-> !busy_reg [*8])
    else $error("busy rose too early after forced request");
  busy_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(start_reg) |-> busy_reg ##1 (busy_reg || done_reg))
    else $error("busy not raised with sensor start");
endmodule : rtc_force_temp_conversion_engine

// *** verilog/rtc_control_status_regs.sv ***
`timescale 1ns/1ps
module rtc_control_status_regs import rtc_pkg::*; #(
  parameter int unsigned BUSY_DELAY = RTC_BUSY_DLY_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic on_battery,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic one_hz_tick,
  input wire logic ref_clk_in,
  input wire logic osc_stop_event,
  input wire logic alarm_one_match,
  input wire logic alarm_two_match,
  input wire logic sensor_done,
  input wire logic [9:0] sensor_temp,
  output logic sensor_start,
  output logic trim_apply,
  output logic [7:0] trim_value,
  output logic osc_enable,
  output logic ref_clock_pin,
  output logic irq_wave_o,
  output logic irq_wave_oe_n,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata
);
  // ==========================================================
  // Address decode
  function automatic logic rtc_hit(input logic [7:0] addr, input logic [7:0] ofs,
                                   input logic wr);
    rtc_hit = (addr == (wr ? (ofs | RTC_WR_FLAG) : ofs));
  endfunction : rtc_hit

  // Automatic conversion interval in seconds
  function automatic logic [9:0] rtc_interval(input logic [1:0] rate);
    rtc_interval = RTC_COMP_BASE_S << rate;
  endfunction : rtc_interval

  rtc_force_temp_conversion_if cv ();

  logic [7:0] ctrl_reg;
  logic [7:0] stat_reg;
  logic [7:0] trim_reg;
  logic tctl_reg;
  logic [7:0] mptr_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic osc_run_reg;
  logic ref_out_reg;
  logic ref_prev_reg;
  logic [RTC_DIV_W-1:0] div_reg;
  logic oe_n_reg;
  logic pin_o_reg;
  logic [9:0] sec_cnt_reg;
  logic auto_pend_reg;
  logic mem_we_reg;
  logic [7:0] mem_wdata_reg;
  logic wr_ctrl;
  logic wr_stat;
  logic win_wr;
  logic win_rd;
  logic wave;
  logic alarm_act;
  logic pin_low;
  logic due;
  logic osf_set;

  // Access strobes: writes at base offset with write flag, window read at base offset
  assign wr_ctrl = reg_wr_en && rtc_hit(reg_addr, RTC_CTRL_OFS, 1'b1);
  assign wr_stat = reg_wr_en && rtc_hit(reg_addr, RTC_STAT_OFS, 1'b1);
  assign win_wr = reg_wr_en && rtc_hit(reg_addr, RTC_MWIN_OFS, 1'b1);
  assign win_rd = reg_rd_en && rtc_hit(reg_addr, RTC_MWIN_OFS, 1'b0);

  // ==========================================================
  // Conversion engine
  assign cv.force_req = wr_ctrl && reg_wdata[CTL_FORCE_TEMP_CONVERSION] && !cv.busy && !cv.force_busy;
  assign cv.auto_req = auto_pend_reg;
  assign cv.sensor_done = sensor_done;
  assign cv.sensor_temp = sensor_temp;

  rtc_force_temp_conversion_engine #(
    .BUSY_DELAY(BUSY_DELAY)
  ) u_engine (
    .clk(clk),
    .sys_rst(sys_rst),
    .cv(cv)
  );

  assign sensor_start = cv.sensor_start;
  assign trim_apply = cv.trim_apply;

  // ==========================================================
  // Control register; conversion bit is the engine's flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= RTC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata & ~(8'h01 << CTL_FORCE_TEMP_CONVERSION);
    end
  end

  // Status register: configuration bits on write, one process for the whole byte
  // Sticky flags; a set in the clearing cycle wins
  assign osf_set = osc_stop_event || !osc_run_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_reg[STA_OSF] <= RTC_STAT_RST[STA_OSF];
      stat_reg[STA_BAT_REF] <= RTC_STAT_RST[STA_BAT_REF];
      stat_reg[STA_CRATE_HI:STA_CRATE_LO] <= RTC_STAT_RST[STA_CRATE_HI:STA_CRATE_LO];
      stat_reg[STA_REF_EN] <= RTC_STAT_RST[STA_REF_EN];
      stat_reg[STA_BUSY] <= 1'b0;
      stat_reg[STA_A2F] <= RTC_STAT_RST[STA_A2F];
      stat_reg[STA_A1F] <= RTC_STAT_RST[STA_A1F];
    end else begin
      if (wr_stat) begin
        stat_reg[STA_BAT_REF] <= reg_wdata[STA_BAT_REF];
        stat_reg[STA_CRATE_HI:STA_CRATE_LO] <= reg_wdata[STA_CRATE_HI:STA_CRATE_LO];
        stat_reg[STA_REF_EN] <= reg_wdata[STA_REF_EN];
      end
      stat_reg[STA_BUSY] <= 1'b0;
      stat_reg[STA_OSF] <= osf_set ||
        (stat_reg[STA_OSF] && !(wr_stat && !reg_wdata[STA_OSF]));
      stat_reg[STA_A2F] <= alarm_two_match ||
        (stat_reg[STA_A2F] && !(wr_stat && !reg_wdata[STA_A2F]));
      stat_reg[STA_A1F] <= alarm_one_match ||
        (stat_reg[STA_A1F] && !(wr_stat && !reg_wdata[STA_A1F]));
    end
  end

  // Trim, temperature control and memory pointer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_reg <= RTC_ZERO_RST;
      tctl_reg <= RTC_ZERO_RST[TCTL_BAT_TD];
      mptr_reg <= RTC_ZERO_RST;
    end else begin
      if (reg_wr_en && rtc_hit(reg_addr, RTC_TRIM_OFS, 1'b1)) begin
        trim_reg <= reg_wdata;
      end
      if (reg_wr_en && rtc_hit(reg_addr, RTC_TCTL_OFS, 1'b1)) begin
        tctl_reg <= reg_wdata[TCTL_BAT_TD];
      end
      if (reg_wr_en && rtc_hit(reg_addr, RTC_MPTR_OFS, 1'b1)) begin
        mptr_reg <= reg_wdata;
      end else if (win_wr || win_rd) begin
        mptr_reg <= mptr_reg + 8'h01;
      end
    end
  end

  // Memory write strobe toward the array
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= RTC_ZERO_RST;
    end else begin
      mem_we_reg <= win_wr;
      if (win_wr) begin
        mem_wdata_reg <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Read mux; unmapped and write addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      RTC_CTRL_OFS: rdata_next = ctrl_reg | ({7'h00, cv.force_busy} << CTL_FORCE_TEMP_CONVERSION);
      RTC_STAT_OFS: rdata_next = stat_reg | ({7'h00, cv.busy} << STA_BUSY);
      RTC_TRIM_OFS: rdata_next = trim_reg;
      RTC_TEMPH_OFS: rdata_next = cv.temp[9:2];
      RTC_TEMPL_OFS: rdata_next = {cv.temp[1:0], 6'h00};
      RTC_TCTL_OFS: rdata_next = {7'h00, tctl_reg};
      RTC_MPTR_OFS: rdata_next = mptr_reg;
      RTC_MWIN_OFS: rdata_next = mem_rdata;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Periodic conversion timer, free of forced requests
  assign due = one_hz_tick &&
    (sec_cnt_reg >= rtc_interval(stat_reg[STA_CRATE_HI:STA_CRATE_LO]) - 10'h001);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt_reg <= 10'h000;
    end else if (due) begin
      sec_cnt_reg <= 10'h000;
    end else if (one_hz_tick) begin
      sec_cnt_reg <= sec_cnt_reg + 10'h001;
    end
  end

  // Pending automatic request; set at reset for the first reading
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_pend_reg <= 1'b1;
    end else if (due && !(on_battery && tctl_reg)) begin
      auto_pend_reg <= 1'b1;
    end else if (cv.auto_ack) begin
      auto_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Oscillator enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_run_reg <= 1'b1;
    end else begin
      osc_run_reg <= !(on_battery && ctrl_reg[CTL_OSC_DIS]);
    end
  end

  // Reference clock output and wave divider
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_out_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      div_reg <= '0;
    end else begin
      ref_prev_reg <= ref_clk_in;
      if (ref_clk_in && !ref_prev_reg) begin
        div_reg <= div_reg + 1'b1;
      end
      ref_out_reg <= ref_clk_in && stat_reg[STA_REF_EN] &&
        (!on_battery || stat_reg[STA_BAT_REF]);
    end
  end

  // Wave rate and alarm interrupt selection
  always_comb begin
    case (ctrl_reg[CTL_RATE_HI:CTL_RATE_LO])
      2'h0: wave = div_reg[RTC_TAP_1HZ];
      2'h1: wave = div_reg[RTC_TAP_1K];
      2'h2: wave = div_reg[RTC_TAP_4K];
      2'h3: wave = div_reg[RTC_TAP_8K];
      default: wave = 1'b0;
    endcase
  end
  assign alarm_act = (stat_reg[STA_A1F] && ctrl_reg[CTL_A1_IE]) ||
    (stat_reg[STA_A2F] && ctrl_reg[CTL_A2_IE]);
  assign pin_low = ctrl_reg[CTL_IRQ_SEL] ? alarm_act : !wave;

  // Open-drain pin: enable low pulls the line low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_n_reg <= 1'b1;
      pin_o_reg <= 1'b0;
    end else begin
      pin_o_reg <= 1'b0;
      oe_n_reg <= (on_battery && !ctrl_reg[CTL_BAT_INT]) || !pin_low;
    end
  end

  assign reg_rdata = rdata_reg;
  assign trim_value = trim_reg;
  assign osc_enable = osc_run_reg;
  assign ref_clock_pin = ref_out_reg;
  assign irq_wave_o = pin_o_reg;
  assign irq_wave_oe_n = oe_n_reg;
  assign mem_addr = mptr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_we = mem_we_reg;

  // ==========================================================
  // Checks
  default clocking ck @(posedge clk); endclocking
  default disable iff (sys_rst);

  osc_main_on_a: assert property (!on_battery |=> osc_enable)
    else $error("oscillator off on main supply");
  irq_float_a: assert property (on_battery && !ctrl_reg[CTL_BAT_INT] |=> irq_wave_oe_n)
    else $error("irq pin driven on battery");
  force_take_a: assert property (cv.force_req |=> cv.force_busy ##1 cv.force_busy)
    else $error("forced request not accepted");
  force_end_a: assert property ($fell(cv.force_busy) |-> !cv.busy && cv.done)
    else $error("conversion bit and busy did not clear together");
  alarm_set_a: assert property (alarm_one_match |=> stat_reg[STA_A1F])
    else $error("alarm flag not set on match");
  irq_alarm_a: assert property (stat_reg[STA_A1F] && ctrl_reg[CTL_A1_IE] &&
    ctrl_reg[CTL_IRQ_SEL] && !on_battery |=> !irq_wave_oe_n)
    else $error("alarm did not pull pin low");
  flag_keep_a: assert property (wr_stat && reg_wdata[STA_A2F] &&
    !stat_reg[STA_A2F] && !alarm_two_match |=> !stat_reg[STA_A2F])
    else $error("writing one set an alarm flag");
  osf_sticky_a: assert property (stat_reg[STA_OSF] && !wr_stat |=> stat_reg[STA_OSF])
    else $error("stop flag cleared without write");
  ref_batt_a: assert property (on_battery && !stat_reg[STA_BAT_REF] |=> !ref_clock_pin)
    else $error("reference clock on battery without enable");
  ref_off_a: assert property (!stat_reg[STA_REF_EN] |=> !ref_clock_pin)
    else $error("reference clock while disabled");
  ptr_wrap_a: assert property ((win_rd || win_wr) && mptr_reg == 8'hFF |=>
    mem_addr == 8'h00)
    else $error("memory pointer did not wrap");
  zero_bits_a: assert property (reg_rd_en && reg_addr == RTC_TEMPL_OFS |=>
    reg_rdata[5:0] == 6'h00)
    else $error("constant zero bits read nonzero");

  forced_run_c: cover property (cv.force_req ##[1:1000] cv.done);
  alarm_two_c: cover property (alarm_two_match ##1 stat_reg[STA_A2F]);
  alarm_irq_c: cover property (alarm_one_match ##1 !irq_wave_oe_n);
  auto_run_c: cover property (due ##[1:20] cv.sensor_start);
  ptr_wrap_c: cover property (win_wr && mptr_reg == 8'hFF);
endmodule : rtc_control_status_regs

// *** tb/rtc_sensor_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Temperature sensor: answers each start after a fixed delay
module rtc_sensor_model #(
  parameter int DLY = 30
) (
  input wire logic clk,
  input wire logic start,
  output logic done,
  output logic [9:0] temp
);
  logic [9:0] val_reg;
  // Result changes per conversion; bus shows junk outside done
  initial begin
    done = 1'b0;
    val_reg = 10'h2D5;
    temp = ~val_reg;
  end
  // Conversion run
  always begin
    @(posedge clk iff start === 1'b1);
    repeat (DLY) @(posedge clk);
    @(negedge clk);
    done = 1'b1;
    temp = val_reg;
    @(negedge clk);
    done = 1'b0;
    temp = ~val_reg;
    val_reg = val_reg + 10'h001;
  end
endmodule : rtc_sensor_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench for the control and status register bank
module tb;
  import rtc_pkg::*;
  logic clk, sys_rst, on_battery, reg_wr_en, reg_rd_en, ref_clk_in, a1_match;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, trim_value, mem_addr, mem_wdata, rd_val;
  logic sensor_start, sensor_done, trim_apply, osc_enable, ref_clock_pin;
  logic irq_wave_o, irq_wave_oe_n, mem_we, hi_seen, bad, tick, a2_match;
  logic [9:0] sensor_temp;
  int fails, compares, trims, starts;
  localparam logic [7:0] W = RTC_WR_FLAG;
  rtc_control_status_regs #(.BUSY_DELAY(20)) u_rtc_control_status_regs (
    .clk(clk), .sys_rst(sys_rst), .on_battery(on_battery), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .one_hz_tick(tick), .ref_clk_in(ref_clk_in),
    .osc_stop_event(1'b0), .alarm_one_match(a1_match), .alarm_two_match(a2_match),
    .sensor_done(sensor_done), .sensor_temp(sensor_temp), .sensor_start(sensor_start),
    .trim_apply(trim_apply), .trim_value(trim_value), .osc_enable(osc_enable),
    .ref_clock_pin(ref_clock_pin), .irq_wave_o(irq_wave_o),
    .irq_wave_oe_n(irq_wave_oe_n), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem_addr ^ 8'h5A));
  rtc_sensor_model u_rtc_sensor_model (.clk(clk), .start(sensor_start),
    .done(sensor_done), .temp(sensor_temp));
  // Clock and reference source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always begin
    repeat (8) @(negedge clk);
    ref_clk_in = ~ref_clk_in;
  end
  // Trim pulse counter
  always @(negedge clk) if (trim_apply === 1'b1) trims++;
  // Sensor start pulse counter
  always @(negedge clk) if (sensor_start === 1'b1) starts++;
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk) reg_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk) reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk) reg_rd_en = 1'b0;
    rd_val = reg_rdata;
  endtask : rd
  task automatic complete_run;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(RTC_TEMPH_OFS); chk(rd_val, 8'h00);
    rd(RTC_TEMPL_OFS); chk(rd_val, 8'h00);
    rd(RTC_CTRL_OFS); chk(rd_val, 8'h1C);
    rd(RTC_STAT_OFS); chk(rd_val & 8'hFB, 8'h88);
    rd(RTC_TRIM_OFS); chk(rd_val, 8'h00);
    rd(8'h14); chk(rd_val, 8'h00);
    rd(RTC_CTRL_OFS | W); chk(rd_val, 8'h00);
  endtask : t_reset
  task automatic t_first_force_temp_conversion;
    int i;
    i = 0;
    do rd(RTC_STAT_OFS); while (rd_val[STA_BUSY] !== 1'b0 && ++i < 100);
    chk(trims[7:0], 8'h01);
    rd(RTC_TEMPH_OFS); chk(rd_val, 8'hB5);
    rd(RTC_TEMPL_OFS); chk(rd_val, 8'h40);
  endtask : t_first_force_temp_conversion
  task automatic t_forced;
    int i;
    i = 0;
    wr(RTC_CTRL_OFS | W, 8'h3C);
    rd(RTC_CTRL_OFS); chk(rd_val, 8'h3C);
    rd(RTC_STAT_OFS); chk(rd_val & 8'h04, 8'h00);
    wr(RTC_CTRL_OFS | W, 8'h3C);
    do rd(RTC_CTRL_OFS); while (rd_val[CTL_FORCE_TEMP_CONVERSION] === 1'b1 && ++i < 100);
    chk(rd_val, 8'h1C);
    rd(RTC_STAT_OFS); chk(rd_val & 8'h04, 8'h00);
    chk(trims[7:0], 8'h02);
    rd(RTC_TEMPH_OFS); chk(rd_val, 8'hB5);
    rd(RTC_TEMPL_OFS); chk(rd_val, 8'h80);
  endtask : t_forced
  task automatic t_alarm;
    wr(RTC_CTRL_OFS | W, 8'h1D);
    @(negedge clk) a1_match = 1'b1;
    @(negedge clk) a1_match = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq_wave_oe_n}, 8'h00);
    rd(RTC_STAT_OFS); chk(rd_val & 8'h03, 8'h01);
    wr(RTC_STAT_OFS | W, 8'h0B);
    rd(RTC_STAT_OFS); chk(rd_val & 8'h03, 8'h01);
    wr(RTC_STAT_OFS | W, 8'h08);
    rd(RTC_STAT_OFS); chk(rd_val & 8'hFB, 8'h08);
    repeat (2) @(negedge clk);
    chk({7'h00, irq_wave_oe_n}, 8'h01);
    wr(RTC_CTRL_OFS | W, 8'h1E);
    @(negedge clk) a2_match = 1'b1;
    @(negedge clk) a2_match = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq_wave_oe_n}, 8'h00);
    rd(RTC_STAT_OFS); chk(rd_val & 8'h03, 8'h02);
    wr(RTC_STAT_OFS | W, 8'h08);
  endtask : t_alarm
  task automatic t_wave;
    logic lo, hi;
    lo = 1'b0;
    hi = 1'b0;
    wr(RTC_CTRL_OFS | W, 8'h18);
    repeat (80) @(negedge clk) begin
      lo |= ~irq_wave_oe_n;
      hi |= irq_wave_oe_n;
    end
    chk({6'h00, lo, hi}, 8'h03);
    chk({7'h00, irq_wave_o}, 8'h00);
  endtask : t_wave
  task automatic t_periodic;
    int s;
    s = starts;
    @(negedge clk) tick = 1'b1;
    wr(RTC_CTRL_OFS | W, 8'h3C);
    repeat (61) @(negedge clk);
    chk(starts[7:0], s[7:0] + 8'h01);
    @(negedge clk) tick = 1'b0;
    repeat (2) @(negedge clk);
    chk(starts[7:0], s[7:0] + 8'h02);
    on_battery = 1'b1;
    @(negedge clk) tick = 1'b1;
    repeat (70) @(negedge clk);
    tick = 1'b0;
    on_battery = 1'b0;
    repeat (4) @(negedge clk);
    chk(starts[7:0], s[7:0] + 8'h02);
    chk(trims[7:0], 8'h04);
  endtask : t_periodic
  task automatic t_regs;
    wr(RTC_TRIM_OFS | W, 8'h80);
    rd(RTC_TRIM_OFS); chk(rd_val, 8'h80);
    chk(trim_value, 8'h80);
    wr(RTC_TCTL_OFS | W, 8'hFF);
    rd(RTC_TCTL_OFS); chk(rd_val, 8'h01);
    wr(RTC_TEMPH_OFS | W, 8'h12);
    rd(RTC_TEMPH_OFS); chk(rd_val, 8'hB5);
  endtask : t_regs
  task automatic t_mem;
    wr(RTC_MPTR_OFS | W, 8'hFF);
    wr(RTC_MWIN_OFS | W, 8'hA5);
    chk({7'h00, mem_we}, 8'h01);
    chk(mem_wdata, 8'hA5);
    chk(mem_addr, 8'h00);
    wr(RTC_MPTR_OFS | W, 8'h10);
    rd(RTC_MWIN_OFS); chk(rd_val, 8'h4A);
    rd(RTC_MPTR_OFS); chk(rd_val, 8'h11);
  endtask : t_mem
  task automatic t_battery;
    hi_seen = 1'b0;
    bad = 1'b0;
    repeat (40) @(negedge clk) hi_seen |= ref_clock_pin;
    chk({7'h00, hi_seen}, 8'h01);
    on_battery = 1'b1;
    repeat (2) @(negedge clk);
    repeat (40) @(negedge clk) bad |= ref_clock_pin | ~irq_wave_oe_n;
    chk({7'h00, bad}, 8'h00);
    chk({7'h00, osc_enable}, 8'h01);
    wr(RTC_CTRL_OFS | W, 8'h9C);
    repeat (2) @(negedge clk);
    chk({7'h00, osc_enable}, 8'h00);
    rd(RTC_STAT_OFS); chk(rd_val & 8'h80, 8'h80);
  endtask : t_battery
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {sys_rst, on_battery, reg_wr_en, reg_rd_en, ref_clk_in, a1_match, a2_match, tick} = 8'h80;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_first_force_temp_conversion();
    t_forced();
    t_alarm();
    t_regs();
    t_mem();
    t_wave();
    t_periodic();
    t_battery();
    complete_run();
  end
  initial begin
    #100us;
    fails++;
    complete_run();
  end
endmodule : tb
